// File: rtl/slsd_ctrl.sv
// Purpose: controller end, shifts words out and pulses latch load
// Assumes: words queue in a 16-word fifo; blank given as its own level input
// Notes:   serial clock from a divider, at most 10 MHz
`timescale 1ns/10ps
`default_nettype none
module slsd_ctrl
  import slsd_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    wr_valid,
  output logic                         wr_ready,
  input  wire logic [slsd_pkg::NUM_CH-1:0] wr_data,
  input  wire logic                    blank_req,
  output logic                         busy,
  slsd_if.ctl                          lnk
);
  import slsd_pkg::*;
  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_SETUP, ST_LOAD, ST_HOLD} slsd_st_t;
  typedef struct packed {
    slsd_st_t          st;
    logic [NUM_CH-1:0] sh;
    logic [4:0]        bits;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  bcnt;
    logic              sclk;
    logic              sdin;
    logic              ld;
    logic              blank;
    logic              busy;
  } slsd_ctl_t;
  slsd_ctl_t s_q;
  slsd_ctl_t s_d;
  logic              f_valid;
  logic              f_ready;
  logic [NUM_CH-1:0] f_data;
  // ----------------------------------------------------------------
  // word queue; back-pressure reaches wr_ready
  // ----------------------------------------------------------------
  slsd_fifo #(.WIDTH(NUM_CH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign f_ready = (s_q.st == ST_IDLE);
  always_comb begin
    s_d = s_q;
    s_d.busy = (s_q.st != ST_IDLE) || f_valid;
    if (s_q.cnt != CNT_ZERO) begin
      s_d.cnt = s_q.cnt - CNT_ONE;
    end
    // blank changes held a minimum width
    if (s_q.bcnt != CNT_ZERO) begin
      s_d.bcnt = s_q.bcnt - CNT_ONE;
    end else if (blank_req != s_q.blank) begin
      s_d.blank = blank_req;
      s_d.bcnt  = CNT_W'(BLANK_WIDTH_CYC);
    end
    case (s_q.st)
      ST_IDLE: begin
        if (f_valid) begin
          s_d.sh   = f_data;
          s_d.bits = 5'(NUM_CH);
          s_d.st   = ST_LOW;
          s_d.cnt  = CNT_W'(SCLK_HALF_CYC);
        end
      end
      ST_LOW: begin
        s_d.sclk = 1'b0;
        s_d.sdin = s_q.sh[NUM_CH-1];
        if (s_q.cnt == CNT_ZERO) begin
          s_d.st   = ST_HIGH;
          s_d.cnt  = CNT_W'(SCLK_HALF_CYC);
        end
      end
      ST_HIGH: begin
        s_d.sclk = 1'b1;
        if (s_q.cnt == CNT_ZERO) begin
          s_d.sclk = 1'b0;
          s_d.sh   = {s_q.sh[NUM_CH-2:0], 1'b0};
          s_d.bits = s_q.bits - 5'h01;
          s_d.cnt  = CNT_W'(SCLK_HALF_CYC);
          s_d.st   = (s_q.bits == 5'h01) ? ST_SETUP : ST_LOW;
          if (s_q.bits == 5'h01) begin
            s_d.cnt = CNT_W'(LATCH_SETUP_CYC);
          end
        end
      end
      ST_SETUP: begin
        if (s_q.cnt == CNT_ZERO) begin
          s_d.ld  = 1'b1;
          s_d.cnt = CNT_W'(LATCH_WIDTH_CYC);
          s_d.st  = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (s_q.cnt == CNT_ZERO) begin
          s_d.ld = 1'b0; // latch load never left high, so no case
          s_d.st = ST_HOLD;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.blank <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign lnk.sclk     = s_q.sclk;
  assign lnk.sdin     = s_q.sdin;
  assign lnk.latch_ld = s_q.ld;
  assign lnk.blank    = s_q.blank;
  assign busy         = s_q.busy;
endmodule : slsd_ctrl
`default_nettype wire

// File: rtl/slsd_driver.sv
// Purpose: serial-in latched sink driver logic, device end
// Assumes: link pins arrive from outside the clock domain
// Notes:   sink_on high means the sink is conducting
//
// Overview of operation
// - rising serial clock loads data into stage 0
// - later edges shift toward serial data out
// - latch load high copies stages to latches
// - latches transparent while latch load high
// - controller keeps latch load low during shifting
// - blank high turns every sink off
// - blank never alters latch contents
// - blank low: each sink follows its latch
// - controller keeps serial clock at most 10 MHz
// - controller waits 100 ns before latch load
// - controller holds latch load at least 100 ns
// - controller blank pulses last at least 4.5 us
`timescale 1ns/10ps
`default_nettype none
module slsd_driver
  import slsd_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  slsd_if.drv                    lnk,
  output logic [slsd_pkg::NUM_CH-1:0] sink_on,
  output logic [slsd_pkg::NUM_CH-1:0] latch_view
);
  import slsd_pkg::*;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        sclk_s;  // [0],[1] sync, [2] edge history
    logic [1:0]        sdin_s;
    logic [1:0]        ld_s;
    logic [1:0]        blank_s;
    logic [NUM_CH-1:0] shreg;
    logic [NUM_CH-1:0] latch;
    logic [NUM_CH-1:0] sink;
    logic              sdout;
  } slsd_drv_t;
  slsd_drv_t s_q;
  slsd_drv_t s_d;
  logic [NUM_CH-1:0] shift_nx;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.sclk_s  = {s_q.sclk_s[1:0], lnk.sclk};
    s_d.sdin_s  = {s_q.sdin_s[0], lnk.sdin};
    s_d.ld_s    = {s_q.ld_s[0], lnk.latch_ld};
    s_d.blank_s = {s_q.blank_s[0], lnk.blank};
    shift_nx    = s_q.shreg;
    // data is sampled with the edge; same sync depth keeps setup order
    if (s_q.sclk_s[1] && !s_q.sclk_s[2]) begin
      shift_nx = {s_q.shreg[NUM_CH-2:0], s_q.sdin_s[1]};
    end
    s_d.shreg = shift_nx;
    s_d.sdout = shift_nx[NUM_CH-1];
    // transparent: latch follows the updated register, else holds
    if (s_q.ld_s[1]) begin
      s_d.latch = shift_nx;
    end
    // blank only gates the sinks, latch path untouched
    s_d.sink = s_q.blank_s[1] ? PAT_ZERO : s_d.latch;
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_q         <= '0;
      s_q.blank_s <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end
  assign lnk.sdout  = s_q.sdout;
  assign sink_on    = s_q.sink;
  assign latch_view = s_q.latch;
endmodule : slsd_driver
`default_nettype wire

// File: rtl/slsd_fifo.sv
// Purpose: small flip-flop FIFO with valid and ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/10ps
`default_nettype none
module slsd_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q[AW-1:0]] <= in_data;
        wr_q                <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : slsd_fifo
`default_nettype wire

// File: rtl/slsd_if.sv
// Purpose: serial link pins between controller and sink driver
// Assumes: all pins one-way, driven by plain logic
// Notes:   no clocking block; testbench samples directly
`timescale 1ns/10ps
`default_nettype none
interface slsd_if;
  logic sclk;     // serial clock
  logic sdin;     // serial data into the driver
  logic sdout;    // serial data out, for cascading
  logic latch_ld; // latch load, transparent while high
  logic blank;    // output blank, active high
  modport drv (input sclk, input sdin, input latch_ld, input blank, output sdout);
  modport ctl (output sclk, output sdin, output latch_ld, output blank, input sdout);
endinterface : slsd_if
`default_nettype wire

// File: rtl/slsd_pkg.sv
// Purpose: shared constants and types for the serial latched sink driver
// Assumes: one 20 MHz clock, ref_clk
// Notes:   times in ns, cycle counts derived from the clock period
package slsd_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH       = 16;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // ----------------------------------------------------------------
  // timing, as printed, then cycles (least times round up)
  // ----------------------------------------------------------------
  localparam int unsigned SCLK_MAX_MHZ    = 10;
  localparam int unsigned SCLK_HALF_NS    = 1000 / (2 * SCLK_MAX_MHZ);
  localparam int unsigned LATCH_SETUP_NS  = 100;
  localparam int unsigned LATCH_WIDTH_NS  = 100;
  localparam int unsigned BLANK_WIDTH_NS  = 4500;
  localparam int unsigned SCLK_HALF_CYC   =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LATCH_SETUP_CYC =
    (LATCH_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LATCH_WIDTH_CYC =
    (LATCH_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_WIDTH_CYC =
    (BLANK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [NUM_CH-1:0] PAT_ZERO = 16'h0000;
  localparam logic [NUM_CH-1:0] ALL_OFF  = 16'hffff;
endpackage : slsd_pkg

// File: testbench/slsd_link_sva.sv
// Purpose: link and sink checks for the serial latched sink driver
// Assumes: one clock, synchronous active-low reset
// Notes:   blank spacing kept in a saturating counter, so long holds never wrap
`timescale 1ns/10ps
`default_nettype none
module slsd_link_sva (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        sdin,
  input  wire logic        sdout,
  input  wire logic        latch_ld,
  input  wire logic        blank,
  input  wire logic [15:0] sink_on,
  input  wire logic [15:0] latch_view
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  typedef struct packed {logic [7:0] cnt; logic blank;} slsd_chk_t;
  slsd_chk_t st_q;
  slsd_chk_t st_d;
  always_comb begin
    st_d       = st_q;
    st_d.blank = blank;
    if (blank != st_q.blank) st_d.cnt = 8'h01;
    else if (st_q.cnt != 8'hff) st_d.cnt = st_q.cnt + 8'h01;
  end
  // starts saturated: no spacing owed from before reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) st_q <= {8'hff, 1'b1};
    else st_q <= st_d;
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_sclk_high; $rose(sclk) |=> ##[0:1] !sclk; endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high time wrong");
  property p_sclk_low; $fell(sclk) |=> !sclk; endproperty
  a_sclk_low: assert property (p_sclk_low)
    else $error("serial clock low time too short");
  // data does not move in the same cycle as a serial clock edge
  property p_data_steady; $changed(sclk) |-> $stable(sdin); endproperty
  a_data_steady: assert property (p_data_steady)
    else $error("serial data moved at a clock edge");
  // sdout moves only on a shift; three edges covers the two-flop sync
  property p_sdout_shift; $changed(sdout) |-> $past(sclk, 3); endproperty
  a_sdout_shift: assert property (p_sdout_shift)
    else $error("serial data out moved without a shift");
  property p_latch_setup; $rose(latch_ld) |-> !$past(sclk) && !$past(sclk, 2); endproperty
  a_latch_setup: assert property (p_latch_setup)
    else $error("latch load too soon after shift");
  property p_latch_width; $rose(latch_ld) |=> latch_ld; endproperty
  a_latch_width: assert property (p_latch_width)
    else $error("latch load pulse too short");
  property p_no_shift_loaded; latch_ld |-> !sclk; endproperty
  a_no_shift_loaded: assert property (p_no_shift_loaded)
    else $error("shifting while latches open");
  property p_blank_width; (blank != st_q.blank) |-> st_q.cnt >= 8'h5a; endproperty
  a_blank_width: assert property (p_blank_width)
    else $error("blank pulse too short");
  property p_blank_off; blank [*4] |-> sink_on == 16'h0000; endproperty
  a_blank_off: assert property (p_blank_off)
    else $error("sink on while blanked");
  // sink and latch register on the same edge once unblanked
  property p_sink_follow; (!blank) [*5] |-> sink_on == latch_view; endproperty
  a_sink_follow: assert property (p_sink_follow)
    else $error("sink does not follow latch");
  property p_latch_hold; (!latch_ld) [*4] |=> $stable(latch_view); endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch moved while load low");
  property p_blank_keep;
    (!latch_ld) [*4] ##0 (blank != st_q.blank) |=> $stable(latch_view);
  endproperty
  a_blank_keep: assert property (p_blank_keep)
    else $error("blank change altered latch");
endmodule : slsd_link_sva
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: drives words through the controller into the sink driver
// Assumes: 20 MHz ref_clk, synchronous active-low reset
// Notes:   expectations come from the written words, plus the blank and back-pressure checks
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, got, exp); end end
module testbench;
  import slsd_pkg::*;
  logic              ref_clk;
  logic              resetn;
  logic              wr_valid;
  logic              wr_ready;
  logic [NUM_CH-1:0] wr_data;
  logic              blank_req;
  logic              busy;
  logic [NUM_CH-1:0] sink_on;
  logic [NUM_CH-1:0] latch_view;
  int                errors;
  int                tests_run;
  int                cyc;
  int                refused;
  slsd_if slsd_if_i ();
  slsd_ctrl slsd_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .blank_req(blank_req), .busy(busy),
    .lnk(slsd_if_i.ctl));
  slsd_driver slsd_driver_i (.ref_clk(ref_clk), .resetn(resetn), .lnk(slsd_if_i.drv),
    .sink_on(sink_on), .latch_view(latch_view));
  slsd_link_sva slsd_link_sva_i (.ref_clk(ref_clk), .resetn(resetn),
    .sclk(slsd_if_i.sclk), .sdin(slsd_if_i.sdin), .sdout(slsd_if_i.sdout),
    .latch_ld(slsd_if_i.latch_ld), .blank(slsd_if_i.blank), .sink_on(sink_on),
    .latch_view(latch_view));
  // ----------------------------------------------------------------
  // clock, watchdog, tasks
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // holds valid and data until the edge that sees ready
  task automatic push(input logic [NUM_CH-1:0] d);
    int n;
    n = 0;
    wr_data  <= d;
    wr_valid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (wr_ready !== 1'b1) refused++;
      n++;
    end while (wr_ready !== 1'b1 && n < 500);
    if (n >= 500) errors++;
  endtask : push
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) errors++;
    repeat (10) @(posedge ref_clk);
  endtask : idle
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    resetn    = 1'b0;
    wr_valid  = 1'b0;
    wr_data   = 16'h0000;
    blank_req = 1'b0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    `CHK(sink_on, 16'h0000)
    // blank changes are spaced, so let the first unblank land
    repeat (120) @(posedge ref_clk);
    push(16'ha5c3);
    wr_valid <= 1'b0;
    idle();
    `CHK(latch_view, 16'ha5c3)
    `CHK(slsd_if_i.sdout, 1'b1)
    `CHK(sink_on, 16'ha5c3)
    push(16'h3c5a);
    wr_valid <= 1'b0;
    idle();
    `CHK(latch_view, 16'h3c5a)
    `CHK(slsd_if_i.sdout, 1'b0)
    blank_req <= 1'b1;
    repeat (120) @(posedge ref_clk);
    `CHK(sink_on, 16'h0000)
    `CHK(latch_view, 16'h3c5a)
    blank_req <= 1'b0;
    repeat (120) @(posedge ref_clk);
    `CHK(sink_on, 16'h3c5a)
    refused = 0;
    for (int i = 0; i < 20; i++) begin
      push(i == 19 ? 16'hffff : 16'h0001 << (i % 16));
    end
    wr_valid <= 1'b0;
    idle();
    `CHK(refused > 0, 1'b1)
    `CHK(latch_view, 16'hffff)
    `CHK(sink_on, 16'hffff)
    `CHK(slsd_if_i.sdout, 1'b1)
    results();
  end
endmodule : testbench
`default_nettype wire
